// >>> cpu_flags_and_address_modes.sv
// Condition flag register, interrupt gating and operand address forming of an 8-bit core
`timescale 1ns/10ps
`default_nettype none
`include "cpu_flags_regs.svh"

module cpu_flags_and_address_modes
	import cpu_flags_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire op_req_t     op_req,
	input  wire addr_req_t   addr_req,
	input  wire logic        instr_boundary,
	input  wire logic        irq_pending,
	input  wire logic        int_regs_saved,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	output logic      [7:0]  condition_flags,
	output logic      [15:0] result,
	output addr_res_t        addr_res,
	output logic             irq_take
);

	// ------------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------------
	logic rst_meta;
	logic rst_sync_n;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------------------
	// Address helpers
	// ------------------------------------------------------------------------
	function automatic logic [1:0] mode_len(input mode_t mode, input logic wide);
		logic [1:0] len;
		len = 2'd0;
		unique case (mode)
			register_only_mode:  len = 2'd0;
			branch_offset_mode:  len = 2'd0;
			inline_operand_mode: len = wide ? 2'd2 : 2'd1;
			page_zero_mode:      len = 2'd1;
			full_address_mode:   len = 2'd2;
			default:             len = 2'd0;
		endcase
		return len;
	endfunction : mode_len

	function automatic logic [15:0] form_addr(input mode_t mode,
	                                          input logic [3:0][7:0] bytes,
	                                          input logic [1:0] idx);
		logic [15:0] addr;
		addr = 16'h0000;
		unique case (mode)
			page_zero_mode:    addr = {`PAGE_ZERO_HI, bytes[idx]};
			full_address_mode: addr = {bytes[idx], bytes[2'(idx + 2'd1)]};
			default:           addr = 16'h0000;
		endcase
		return addr;
	endfunction : form_addr

	function automatic logic is_mem(input mode_t mode);
		return (mode == page_zero_mode) || (mode == full_address_mode);
	endfunction : is_mem

	function automatic logic [15:0] sext8(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction : sext8

	// ------------------------------------------------------------------------
	// Register view
	// ------------------------------------------------------------------------
	// Unmapped offsets read zero so software can probe safely
	function automatic logic [7:0] reg_view(input unit_state_t s, input logic [7:0] addr);
		logic [7:0] v;
		v = 8'h00;
		unique case (addr)
			`REG_CONDITION_FLAGS: v = s.flags | `FLAGS_FIXED_ONES;
			`REG_RESULT_LO:       v = s.result[7:0];
			`REG_RESULT_HI:       v = s.result[15:8];
			`REG_STATUS:          v = {5'h00, s.addr.dst_mem, s.addr.src_mem, s.inhibit};
			`REG_SRC_ADDR_LO:     v = s.addr.src_addr[7:0];
			`REG_SRC_ADDR_HI:     v = s.addr.src_addr[15:8];
			`REG_DST_ADDR_LO:     v = s.addr.dst_addr[7:0];
			`REG_DST_ADDR_HI:     v = s.addr.dst_addr[15:8];
			`REG_TARGET_LO:       v = s.addr.target[7:0];
			`REG_TARGET_HI:       v = s.addr.target[15:8];
			default:              v = 8'h00;
		endcase
		return v;
	endfunction : reg_view

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	unit_state_t st_reg;
	unit_state_t st_next;
	// Reset image: mask set, fixed ones high, everything else clear
	localparam unit_state_t state_at_reset = '{flags: `FLAGS_RESET, default: '0};

	logic [8:0]  sum9;
	logic [4:0]  half5;
	logic [8:0]  diff9;
	logic [7:0]  res8;
	logic [7:0]  daa_fix;
	logic        daa_carry;
	logic [7:0]  f;
	logic        cin;
	logic [1:0]  src_len;
	logic [1:0]  dst_len;
	logic [7:0]  offset;
	logic        mask_was_set;

	always_comb begin
		st_next   = st_reg;
		f         = st_reg.flags;
		cin       = st_reg.flags[`FLAG_C];
		sum9      = 9'h000;
		half5     = 5'h00;
		diff9     = 9'h000;
		res8      = 8'h00;
		daa_fix   = 8'h00;
		daa_carry = 1'b0;
		src_len   = 2'd0;
		dst_len   = 2'd0;
		offset    = 8'h00;
		mask_was_set = st_reg.flags[`FLAG_I];

		// ----------------------------------------------------------------
		// Software flag write
		// ----------------------------------------------------------------
		// Taken first so a same-cycle instruction update wins
		if (reg_write && reg_addr == `REG_CONDITION_FLAGS) begin
			f = reg_wdata;
		end

		// ----------------------------------------------------------------
		// Interrupt hold-off
		// ----------------------------------------------------------------
		// Spent on the first boundary after the unmask
		if (instr_boundary && st_reg.inhibit) begin
			st_next.inhibit = 1'b0;
		end

		// ----------------------------------------------------------------
		// Instruction results
		// ----------------------------------------------------------------
		if (op_req.valid) begin
			f = st_reg.flags;
			unique case (op_req.op)
				op_add, op_adc: begin
					sum9  = {1'b0, op_req.a} + {1'b0, op_req.b}
					      + {8'h00, (op_req.op == op_adc) & cin};
					half5 = {1'b0, op_req.a[3:0]} + {1'b0, op_req.b[3:0]}
					      + {4'h0, (op_req.op == op_adc) & cin};
					res8  = sum9[7:0];
					f[`FLAG_H] = half5[4];
					f[`FLAG_C] = sum9[8];
					f[`FLAG_V] = (op_req.a[7] == op_req.b[7]) && (res8[7] != op_req.a[7]);
				end
				op_sub, op_sbc: begin
					diff9 = {1'b0, op_req.a} - {1'b0, op_req.b}
					      - {8'h00, (op_req.op == op_sbc) & cin};
					res8  = diff9[7:0];
					f[`FLAG_C] = diff9[8];
					f[`FLAG_V] = (op_req.a[7] != op_req.b[7]) && (res8[7] != op_req.a[7]);
				end
				op_and, op_or, op_xor: begin
					res8 = (op_req.op == op_and) ? (op_req.a & op_req.b) :
					       (op_req.op == op_or)  ? (op_req.a | op_req.b) :
					                               (op_req.a ^ op_req.b);
					f[`FLAG_V] = 1'b0;
				end
				op_load8, op_store8: begin
					res8 = op_req.a;
					f[`FLAG_V] = 1'b0;
				end
				op_daa: begin
					// Correction built from the digits and the previous add's carries
					if (st_reg.flags[`FLAG_H] || op_req.a[3:0] > `BCD_DIGIT_MAX) begin
						daa_fix = daa_fix | `BCD_FIX_LO;
					end
					if (st_reg.flags[`FLAG_C] || op_req.a > `BCD_BYTE_MAX) begin
						daa_fix   = daa_fix | `BCD_FIX_HI;
						daa_carry = 1'b1;
					end
					res8 = op_req.a + daa_fix;
					f[`FLAG_C] = daa_carry;
				end
				op_lsl, op_rol: begin
					res8 = {op_req.a[6:0], (op_req.op == op_rol) & cin};
					f[`FLAG_C] = op_req.a[7];
					f[`FLAG_V] = res8[7] ^ op_req.a[7];
				end
				op_lsr, op_ror: begin
					res8 = {(op_req.op == op_ror) & cin, op_req.a[7:1]};
					f[`FLAG_C] = op_req.a[0];
					f[`FLAG_V] = res8[7] ^ op_req.a[0];
				end
				op_dec: begin
					res8 = op_req.a - 8'h01;
					f[`FLAG_V] = (op_req.a == `SIGNED_MIN_BYTE);
				end
				op_cli: begin
					f[`FLAG_I] = 1'b0;
				end
				op_sei: begin
					f[`FLAG_I] = 1'b1;
				end
				op_tap: begin
					f = op_req.a;
				end
				default: begin
					res8 = 8'h00;
				end
			endcase

			// ------------------------------------------------------------
			// Flags shared by all byte results
			// ------------------------------------------------------------
			unique case (op_req.op)
				op_none, op_bittest, op_cli, op_sei, op_tap: begin
				end
				op_load16: begin
					f[`FLAG_N] = op_req.word[15];
					f[`FLAG_Z] = (op_req.word == 16'h0000);
					f[`FLAG_V] = 1'b0;
					st_next.result = op_req.word;
				end
				default: begin
					f[`FLAG_N] = res8[7];
					f[`FLAG_Z] = (res8 == 8'h00);
					st_next.result = {8'h00, res8};
				end
			endcase

			if (op_req.op == op_bittest) begin
				f[`FLAG_C] = op_req.a[op_req.b[2:0]];
			end
		end

		// ----------------------------------------------------------------
		// Interrupt mask
		// ----------------------------------------------------------------
		// Any clear of a set mask holds off the next boundary, whatever path did it
		if (mask_was_set && !f[`FLAG_I]) begin
			st_next.inhibit = 1'b1;
		end

		// Entry mask, applied after the stacking has finished
		if (int_regs_saved) begin
			f[`FLAG_I] = 1'b1;
		end

		st_next.flags = f | `FLAGS_FIXED_ONES;

		// ----------------------------------------------------------------
		// Operand and branch addresses
		// ----------------------------------------------------------------
		// All in the one 16-bit space
		if (addr_req.valid) begin
			src_len = mode_len(addr_req.src_mode, addr_req.wide);
			dst_len = mode_len(addr_req.dst_mode, addr_req.wide);
			st_next.addr.src_addr = form_addr(addr_req.src_mode, addr_req.prog_bytes,
			                                  2'd0);
			st_next.addr.dst_addr = form_addr(addr_req.dst_mode, addr_req.prog_bytes,
			                                  src_len);
			st_next.addr.src_mem  = is_mem(addr_req.src_mode);
			st_next.addr.dst_mem  = is_mem(addr_req.dst_mode);
			st_next.addr.inline_val = addr_req.wide ?
				{addr_req.prog_bytes[0], addr_req.prog_bytes[1]} :
				{8'h00, addr_req.prog_bytes[0]};
			// Offset sits after the tested operand's bytes
			offset = addr_req.prog_bytes[src_len];
			if (addr_req.branch && addr_req.cond) begin
				st_next.addr.target = addr_req.pc + sext8(offset);
			end else begin
				st_next.addr.target = addr_req.pc;
			end
			if (dst_len == 2'd3) begin
				st_next.addr.dst_addr = 16'h0000;
			end
		end

		// ----------------------------------------------------------------
		// Register read port
		// ----------------------------------------------------------------
		st_next.rdata = 8'h00;
		if (reg_read) begin
			st_next.rdata = reg_view(st_reg, reg_addr);
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_reg <= state_at_reset;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign reg_rdata       = st_reg.rdata;
	assign condition_flags = st_reg.flags;
	assign result          = st_reg.result;
	assign addr_res        = st_reg.addr;
	// Gate kept combinational so the boundary decision is same-cycle
	assign irq_take = irq_pending && instr_boundary
	                && !st_reg.flags[`FLAG_I]
	                && !st_reg.inhibit;

endmodule : cpu_flags_and_address_modes
`default_nettype wire

// >>> cpu_flags_and_address_modes_tb.sv
// Self-checking bench of the flag and address unit
`timescale 1ns/10ps
`default_nettype none
module cpu_flags_and_address_modes_tb;
	import cpu_flags_pkg::*;
	logic            clock = 1'b0;
	logic            rstn = 1'b0;
	op_req_t         opr = '0;
	addr_req_t       areq = '0;
	addr_req_t       areq_full;
	logic            bnd = 1'b0;
	logic            pend = 1'b0;
	logic            saved = 1'b0;
	logic [7:0]      raddr = 8'h00;
	logic [7:0]      wdata = 8'h00;
	logic            rwr = 1'b0;
	logic            rrd = 1'b0;
	logic            mwe = 1'b0;
	logic [15:0]     maddr = 16'h0000;
	logic [3:0][7:0] mdata = '0;
	logic [3:0][7:0] fetched;
	logic [7:0]      rdata;
	logic [7:0]      flags;
	logic [15:0]     res;
	addr_res_t       ares;
	logic            take;
	int              errors = 0;
	int              checks = 0;

	always #5 clock = ~clock;
	always_comb begin
		areq_full = areq;
		areq_full.prog_bytes = fetched;
	end

	cpu_flags_and_address_modes dut (
		.clock(clock), .rstn(rstn), .op_req(opr), .addr_req(areq_full),
		.instr_boundary(bnd), .irq_pending(pend), .int_regs_saved(saved),
		.reg_addr(raddr), .reg_wdata(wdata), .reg_write(rwr), .reg_read(rrd),
		.reg_rdata(rdata), .condition_flags(flags), .result(res),
		.addr_res(ares), .irq_take(take)
	);
	// Operand bytes sit four below the instruction end
	mem_space_model mem (
		.clock(clock), .write(mwe), .waddr(maddr), .wbytes(mdata),
		.raddr(areq.pc - 16'h0004), .rbytes(fetched)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run

	// ------------------------------
	// Bus and request drivers
	// ------------------------------
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		raddr <= a;
		wdata <= d;
		rwr <= 1'b1;
		@(posedge clock);
		rwr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		raddr <= a;
		rrd <= 1'b1;
		@(posedge clock);
		rrd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask : reg_rd
	task automatic run_op(input op_t op, input logic [7:0] a, input logic [7:0] b,
			input logic [15:0] w);
		@(posedge clock);
		opr <= '{1'b1, op, a, b, w};
		@(posedge clock);
		opr.valid <= 1'b0;
		@(negedge clock);
	endtask : run_op
	task automatic run_addr(input mode_t s, input mode_t d, input logic w, input logic br,
			input logic c, input logic [15:0] pc);
		@(posedge clock);
		areq <= '{1'b1, s, d, w, br, c, pc, 32'h0};
		@(posedge clock);
		areq.valid <= 1'b0;
		@(negedge clock);
	endtask : run_addr
	task automatic mem_wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		maddr <= a;
		mdata <= d;
		mwe <= 1'b1;
		@(posedge clock);
		mwe <= 1'b0;
	endtask : mem_wr

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_regs;
		logic [7:0] v;
		check(flags, 16'h0068);
		reg_wr(8'h00, 8'h00);
		reg_rd(8'h00, v);
		check(v, 16'h0060);
		reg_rd(8'h03, v);
		check(v, 16'h0001);
		reg_rd(8'hff, v);
		check(v, 16'h0000);
	endtask : t_regs
	task automatic t_arith;
		op_t        ops [6] = '{op_add, op_add, op_add, op_sub, op_and, op_lsl};
		logic [7:0] av [6] = '{8'h08, 8'h80, 8'h7f, 8'h00, 8'h0f, 8'h81};
		logic [7:0] bv [6] = '{8'h08, 8'h80, 8'h01, 8'h01, 8'hf0, 8'h00};
		logic [7:0] rv [6] = '{8'h10, 8'h00, 8'h80, 8'hff, 8'h00, 8'h02};
		logic [7:0] mv [6] = '{8'h97, 8'h97, 8'h97, 8'h87, 8'h86, 8'h87};
		logic [7:0] fv [6] = '{8'h10, 8'h83, 8'h94, 8'h05, 8'h02, 8'h81};
		for (int i = 0; i < 6; i++) begin
			run_op(ops[i], av[i], bv[i], 16'h0000);
			check(res, {8'h00, rv[i]});
			check(flags & mv[i], fv[i]);
		end
		run_op(op_add, 8'h15, 8'h27, 16'h0000);
		run_op(op_daa, 8'h3c, 8'h3c, 16'h0000);
		check(res, 16'h0042);
		run_op(op_add, 8'h09, 8'h09, 16'h0000);
		run_op(op_daa, 8'h12, 8'h12, 16'h0000);
		check(res, 16'h0018);
	endtask : t_arith
	task automatic t_bits;
		logic [7:0] f;
		run_op(op_load16, 8'h00, 8'h00, 16'h0000);
		check(flags & 8'h86, 16'h0002);
		run_op(op_load16, 8'h00, 8'h00, 16'h8001);
		check(flags & 8'h86, 16'h0004);
		f = flags;
		run_op(op_bittest, 8'h04, 8'h02, 16'h0000);
		check(flags, {f[7:1], 1'b1});
		run_op(op_none, 8'h00, 8'h00, 16'h0000);
		check(flags, {f[7:1], 1'b1});
	endtask : t_bits
	task automatic t_irq;
		reg_wr(8'h00, 8'h68);
		@(posedge clock);
		pend <= 1'b1;
		bnd <= 1'b1;
		@(negedge clock);
		check(take, 16'h0000);
		run_op(op_cli, 8'h00, 8'h00, 16'h0000);
		check(take, 16'h0000);
		@(negedge clock);
		check(take, 16'h0001);
		@(posedge clock);
		bnd <= 1'b0;
		saved <= 1'b1;
		@(posedge clock);
		saved <= 1'b0;
		pend <= 1'b0;
		@(negedge clock);
		check(flags[3], 16'h0001);
	endtask : t_irq
	task automatic t_addr;
		mem_wr(16'h0ffc, 32'h78563412);
		mem_wr(16'h1ffc, 32'h000000fe);
		run_addr(page_zero_mode, full_address_mode, 1'b0, 1'b0, 1'b0, 16'h1000);
		check(ares.src_addr, 16'h0012);
		check(ares.dst_addr, 16'h3456);
		run_addr(inline_operand_mode, page_zero_mode, 1'b1, 1'b0, 1'b0, 16'h1000);
		check(ares.inline_val, 16'h1234);
		check(ares.dst_addr, 16'h0056);
		run_addr(full_address_mode, register_only_mode, 1'b0, 1'b0, 1'b0, 16'h1000);
		check(ares.src_addr, 16'h1234);
		check({14'h0000, ares.src_mem, ares.dst_mem}, 16'h0002);
		run_addr(register_only_mode, page_zero_mode, 1'b0, 1'b0, 1'b0, 16'h1000);
		check({14'h0000, ares.src_mem, ares.dst_mem}, 16'h0001);
		check(ares.dst_addr, 16'h0012);
		run_addr(page_zero_mode, register_only_mode, 1'b0, 1'b1, 1'b1, 16'h1000);
		check(ares.target, 16'h1034);
		run_addr(branch_offset_mode, register_only_mode, 1'b0, 1'b1, 1'b1, 16'h2000);
		check(ares.target, 16'h1ffe);
		run_addr(branch_offset_mode, register_only_mode, 1'b0, 1'b1, 1'b0, 16'h2000);
		check(ares.target, 16'h2000);
	endtask : t_addr

	initial begin
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		t_regs;
		t_arith;
		t_bits;
		t_irq;
		t_addr;
		complete_run;
	end
	// Whole run is under a hundred cycles
	initial begin
		#200000;
		errors++;
		complete_run;
	end
endmodule : cpu_flags_and_address_modes_tb
`default_nettype wire

// >>> cpu_flags_pkg.sv
// Types shared by the flag and address unit and its users
package cpu_flags_pkg;

	typedef enum logic [4:0] {
		op_none    = 5'h00,
		op_add     = 5'h01,
		op_adc     = 5'h02,
		op_sub     = 5'h03,
		op_sbc     = 5'h04,
		op_and     = 5'h05,
		op_or      = 5'h06,
		op_xor     = 5'h07,
		op_load8   = 5'h08,
		op_store8  = 5'h09,
		op_load16  = 5'h0a,
		op_daa     = 5'h0b,
		op_lsl     = 5'h0c,
		op_lsr     = 5'h0d,
		op_rol     = 5'h0e,
		op_ror     = 5'h0f,
		op_bittest = 5'h10,
		op_dec     = 5'h11,
		op_cli     = 5'h12,
		op_sei     = 5'h13,
		op_tap     = 5'h14
	} op_t;

	typedef enum logic [2:0] {
		register_only_mode  = 3'h0,
		branch_offset_mode  = 3'h1,
		inline_operand_mode = 3'h3,
		page_zero_mode      = 3'h2,
		full_address_mode   = 3'h6
	} mode_t;

	typedef struct packed {
		logic        valid;
		op_t         op;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [15:0] word;
	} op_req_t;

	typedef struct packed {
		logic            valid;
		mode_t           src_mode;
		mode_t           dst_mode;
		logic            wide;
		logic            branch;
		logic            cond;
		logic [15:0]     pc;
		logic [3:0][7:0] prog_bytes;
	} addr_req_t;

	typedef struct packed {
		logic        src_mem;
		logic        dst_mem;
		logic [15:0] src_addr;
		logic [15:0] dst_addr;
		logic [15:0] target;
		logic [15:0] inline_val;
	} addr_res_t;

	typedef struct packed {
		logic [7:0]  flags;
		logic        inhibit;
		logic [15:0] result;
		addr_res_t   addr;
		logic [7:0]  rdata;
	} unit_state_t;

endpackage : cpu_flags_pkg

// >>> cpu_flags_props.sv
// Port checker for the flag and address unit
`timescale 1ns/10ps
`default_nettype none
module cpu_flags_props
	import cpu_flags_pkg::*;
(
	input wire logic        clock,
	input wire logic        rstn,
	input wire op_req_t     op_req,
	input wire addr_req_t   addr_req,
	input wire logic        instr_boundary,
	input wire logic        irq_pending,
	input wire logic        int_regs_saved,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_read,
	input wire logic [7:0]  reg_rdata,
	input wire logic [7:0]  condition_flags,
	input wire logic [15:0] result,
	input wire addr_res_t   addr_res,
	input wire logic        irq_take
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	logic [8:0]  sum9;
	logic        half_out;
	logic        ovf_out;
	logic [1:0]  load_nz;
	logic [15:0] dst_full;
	logic [15:0] branch_dest;
	assign sum9        = {1'b0, op_req.a} + {1'b0, op_req.b};
	assign half_out    = ({1'b0, op_req.a[3:0]} + {1'b0, op_req.b[3:0]}) > 5'h0f;
	assign ovf_out     = (op_req.a[7] == op_req.b[7]) && (sum9[7] != op_req.a[7]);
	assign load_nz     = {op_req.word[15], op_req.word == 16'h0000};
	assign dst_full    = {addr_req.prog_bytes[1], addr_req.prog_bytes[2]};
	assign branch_dest = addr_req.pc
		+ {{8{addr_req.prog_bytes[0][7]}}, addr_req.prog_bytes[0]};
	sequence add_taken;
		op_req.valid && op_req.op == op_add;
	endsequence
	// Mask just dropped while a boundary is offered
	sequence unmask_step;
		$fell(condition_flags[3]) && instr_boundary;
	endsequence
	a_fixed_ones: assert property (condition_flags[6:5] == 2'b11)
		else $error("fixed flag bits not one");
	a_add_carry: assert property (add_taken |=>
		{condition_flags[0], result[7:0]} == $past(sum9))
		else $error("add carry or sum wrong");
	a_half_carry: assert property (add_taken |=>
		condition_flags[4] == $past(half_out))
		else $error("half carry wrong");
	a_signed_ovf: assert property (add_taken |=>
		condition_flags[7] == $past(ovf_out))
		else $error("overflow flag wrong");
	a_load_flags: assert property (op_req.valid && op_req.op == op_load16 |=>
		condition_flags[2:1] == $past(load_nz))
		else $error("load sign or zero wrong");
	a_page_zero: assert property (addr_req.valid && addr_req.src_mode == page_zero_mode |=>
		addr_res.src_mem && addr_res.src_addr == {8'h00, $past(addr_req.prog_bytes[0])})
		else $error("page zero address wrong");
	a_full_dst: assert property (addr_req.valid && addr_req.src_mode == page_zero_mode
		&& addr_req.dst_mode == full_address_mode |=>
		addr_res.dst_addr == $past(dst_full))
		else $error("destination address wrong");
	a_no_mem_reg: assert property (addr_req.valid
		&& addr_req.src_mode == register_only_mode |=> !addr_res.src_mem)
		else $error("register mode marked memory");
	a_branch_add: assert property (addr_req.valid && addr_req.branch && addr_req.cond
		&& addr_req.src_mode == branch_offset_mode |=> addr_res.target == $past(branch_dest))
		else $error("branch target wrong");
	a_mask_gate: assert property (irq_take |-> irq_pending && instr_boundary
		&& !condition_flags[3])
		else $error("interrupt taken while masked");
	a_entry_mask: assert property (int_regs_saved |=> condition_flags[3])
		else $error("mask not set on entry");
	a_unmask_gap: assert property (unmask_step |-> !irq_take)
		else $error("interrupt right after unmask");
	a_flags_read: assert property (reg_read && reg_addr == 8'h00 |=>
		reg_rdata == $past(condition_flags))
		else $error("flag read data wrong");
endmodule : cpu_flags_props

bind cpu_flags_and_address_modes cpu_flags_props props (
	.clock(clock), .rstn(rstn), .op_req(op_req), .addr_req(addr_req),
	.instr_boundary(instr_boundary), .irq_pending(irq_pending),
	.int_regs_saved(int_regs_saved), .reg_addr(reg_addr), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .condition_flags(condition_flags), .result(result),
	.addr_res(addr_res), .irq_take(irq_take)
);
`default_nettype wire

// >>> cpu_flags_regs.svh
// Offsets, field positions, reset values and fixed constants of the flag and address unit
`ifndef CPU_FLAGS_REGS_SVH
`define CPU_FLAGS_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_CONDITION_FLAGS  8'h00
`define REG_RESULT_LO        8'h01
`define REG_RESULT_HI        8'h02
`define REG_STATUS           8'h03
`define REG_SRC_ADDR_LO      8'h04
`define REG_SRC_ADDR_HI      8'h05
`define REG_DST_ADDR_LO      8'h06
`define REG_DST_ADDR_HI      8'h07
`define REG_TARGET_LO        8'h08
`define REG_TARGET_HI        8'h09

// ----------------------------------------------------------------------------
// Flag bit positions, fixed ones and reset value
// ----------------------------------------------------------------------------
`define FLAG_V               7
`define FLAG_H               4
`define FLAG_I               3
`define FLAG_N               2
`define FLAG_Z               1
`define FLAG_C               0
`define FLAGS_FIXED_ONES     8'h60
`define FLAGS_RESET          8'h68

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define STATUS_INHIBIT       0
`define STATUS_SRC_MEM       1
`define STATUS_DST_MEM       2

// ----------------------------------------------------------------------------
// Arithmetic and address constants
// ----------------------------------------------------------------------------
`define BCD_DIGIT_MAX        4'h9
`define BCD_BYTE_MAX         8'h99
`define BCD_FIX_LO           8'h06
`define BCD_FIX_HI           8'h60
`define SIGNED_MIN_BYTE      8'h80
`define PAGE_ZERO_HI         8'h00

`endif

// >>> mem_space_model.sv
// Program and data space seen by the core
`timescale 1ns/10ps
`default_nettype none
module mem_space_model (
	input  wire logic            clock,
	input  wire logic            write,
	input  wire logic [15:0]     waddr,
	input  wire logic [3:0][7:0] wbytes,
	input  wire logic [15:0]     raddr,
	output logic      [3:0][7:0] rbytes
);
	// One flat space, addresses wrap at the top
	logic [7:0] mem [65536];
	always_ff @(posedge clock) begin
		if (write) begin
			for (int i = 0; i < 4; i++) begin
				mem[waddr + 16'(i)] <= wbytes[i];
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			rbytes[i] = mem[raddr + 16'(i)];
		end
	end
endmodule : mem_space_model
`default_nettype wire
